/* File: hdl/dma_port_cfg.svh */
/*
 constant definitions for the external buffer dma port.
 assumes it is included by bare name from the package and design files.
*/
`ifndef DMA_PORT_CFG_SVH
`define DMA_PORT_CFG_SVH
// ****************************************
// buffer and counter geometry
// ****************************************
`define FIFO_DEPTH 4'h8
`define FIFO_IDX_W 3
`define FIFO_CNT_W 4
`define XFER_CNT_W 24
`define XFER_CNT_ZERO 24'h000000
`define XFER_CNT_ONE 24'h000001
`define BYTE_W 8
`define OFFSET_MAX 4'h8
`define SYNC_ZERO 2'h0
`endif

/* File: hdl/dma_port_pkg.sv */
/*
 types shared by the dma port files.
 assumes the cfg header is on the include path.
*/
`include "dma_port_cfg.svh"
package dma_port_pkg;
  typedef logic [`BYTE_W-1:0] byte_t;
  typedef logic [`XFER_CNT_W-1:0] xfer_cnt_t;
  typedef logic [`FIFO_CNT_W-1:0] fifo_cnt_t;
  // one-hot port states
  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_IN = 3'h2,
    ST_OUT = 3'h4
  } port_state_e;
endpackage : dma_port_pkg

/* File: hdl/sync_edge.sv */
/*
 two-flop synchroniser with falling-edge pulse.
 assumes input is asynchronous to clock.
*/
`timescale 1ns/1ns
`include "dma_port_cfg.svh"
module sync_edge (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic async_in,
  output logic level_out,
  output logic fall_pulse
);
  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [1:0] sync;  // sync[0] is first stage, read only by sync[1]
    logic prev;        // delayed synced level for edge detection
  } sync_s;
  sync_s st_r;
  sync_s st_nxt;
  // next-state: shift chain
  always_comb begin
    st_nxt = st_r;
    st_nxt.sync = {st_r.sync[0], async_in};
    st_nxt.prev = st_r.sync[1];
  end
  // register
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
  assign level_out = st_r.sync[1];
  // one pulse per trailing edge: prev high, synced low
  assign fall_pulse = st_r.prev & ~st_r.sync[1];
endmodule : sync_edge

/* File: hdl/byte_fifo.sv */
/*
 eight-byte flop fifo between scsi side and dma side.
 assumes writer and reader respect full and empty.
*/
`timescale 1ns/1ns
`include "dma_port_cfg.svh"
module byte_fifo (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic flush,
  input wire logic wr_en,
  input dma_port_pkg::byte_t wr_data,
  input wire logic rd_en,
  output dma_port_pkg::byte_t rd_data,
  output logic full,
  output logic empty,
  output dma_port_pkg::fifo_cnt_t count
);
  import dma_port_pkg::*;
  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [`FIFO_DEPTH-1:0][`BYTE_W-1:0] mem;
    logic [`FIFO_IDX_W-1:0] wp;
    logic [`FIFO_IDX_W-1:0] rp;
    fifo_cnt_t cnt;
  } fifo_s;
  fifo_s st_r;
  fifo_s st_nxt;
  logic do_wr;
  logic do_rd;
  // depth judged against eight entries
  assign full = (st_r.cnt == `FIFO_DEPTH);
  assign empty = (st_r.cnt == 4'h0);
  assign do_wr = wr_en & ~full;
  assign do_rd = rd_en & ~empty;
  // next-state: pointer and count update
  always_comb begin
    st_nxt = st_r;
    if (flush) begin
      st_nxt.wp = '0;
      st_nxt.rp = '0;
      st_nxt.cnt = '0;
    end else begin
      if (do_wr) begin
        st_nxt.mem[st_r.wp] = wr_data;
        st_nxt.wp = st_r.wp + 3'h1;
      end
      if (do_rd) begin
        st_nxt.rp = st_r.rp + 3'h1;
      end
      // simultaneous read and write keep the count
      st_nxt.cnt = st_r.cnt + {3'h0, do_wr} - {3'h0, do_rd};
    end
  end
  // register
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
  assign rd_data = st_r.mem[st_r.rp];
  assign count = st_r.cnt;
endmodule : byte_fifo

/* File: hdl/external_buffer_dma_port.sv */
/*
 dma port between the protocol controller byte fifo and an external buffer memory.
 assumes external control logic drives direction and pulses response per byte;
 the scsi side of the fifo is a plain valid/ready byte stream on this clock.
*/
`timescale 1ns/1ns
`include "dma_port_cfg.svh"
module external_buffer_dma_port (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic dma_mode,
  input wire logic xfer_start,
  input wire logic xfer_is_output,
  input dma_port_pkg::xfer_cnt_t xfer_count,
  input wire logic dma_bus_direction_in,
  input wire logic buffer_transfer_response,
  input dma_port_pkg::byte_t dma_data_bus_in,
  input wire logic dma_data_parity_in,
  output dma_port_pkg::byte_t dma_data_bus_out,
  output logic dma_data_parity_out,
  output logic dma_data_oe_n,
  output logic buffer_transfer_request,
  input wire logic scsi_in_valid,
  input dma_port_pkg::byte_t scsi_in_data,
  output logic scsi_in_ready,
  output logic scsi_out_valid,
  output dma_port_pkg::byte_t scsi_out_data,
  input wire logic scsi_out_ready,
  input dma_port_pkg::fifo_cnt_t sync_offset,
  output logic offset_error,
  output logic xfer_done,
  output logic busy,
  output logic parity_error
);
  import dma_port_pkg::*;
  // ****************************************
  // helpers
  // ****************************************
  // odd parity over one byte, used on both directions
  function automatic logic odd_par(input byte_t b);
    odd_par = ~(^b);
  endfunction : odd_par
  // ****************************************
  // reset release and synchronisers
  // ****************************************
  logic [1:0] rst_sync_r; // reset release chain
  logic rst_l_n;          // internal reset copy
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_r <= `SYNC_ZERO;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_l_n = rst_sync_r[1];
  logic dir_s;       // synced direction
  logic resp_s;      // synced response level
  logic resp_fall;   // one pulse per response trailing edge
  // direction needs only a level; its edge output is left open
  sync_edge u_dir_sync (
    .clock(clock),
    .rst_n(rst_l_n),
    .async_in(dma_bus_direction_in),
    .level_out(dir_s),
    .fall_pulse()
  );
  sync_edge u_resp_sync (
    .clock(clock),
    .rst_n(rst_l_n),
    .async_in(buffer_transfer_response),
    .level_out(resp_s),
    .fall_pulse(resp_fall)
  );
  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    port_state_e state;
    byte_t din_s1;      // first sync stage of data, read only by din_s2
    byte_t din_s2;
    logic dpar_s1;
    logic dpar_s2;
    xfer_cnt_t dma_left;   // bytes still to move on the dma side
    xfer_cnt_t scsi_left;  // bytes still to move on the scsi side
    byte_t hold_data;      // byte presented on dma bus in input transfers
    logic hold_par;
    logic hold_valid;
    logic req;
    logic done;
    logic perr;
    logic oerr;
  } port_s;
  port_s st_r;
  port_s st_nxt;
  // ****************************************
  // fifo
  // ****************************************
  logic f_wr;
  byte_t f_wdata;
  logic f_rd;
  byte_t f_rdata;
  logic f_full;
  logic f_empty;
  fifo_cnt_t f_cnt;
  logic f_flush;
  byte_fifo u_fifo (
    .clock(clock),
    .rst_n(rst_l_n),
    .flush(f_flush),
    .wr_en(f_wr),
    .wr_data(f_wdata),
    .rd_en(f_rd),
    .rd_data(f_rdata),
    .full(f_full),
    .empty(f_empty),
    .count(f_cnt)
  );
  logic in_mode;   // scsi to external memory
  logic out_mode;  // external memory to scsi
  logic start_ok;  // start accepted only in dma mode
  logic load_hold; // move next fifo byte onto dma bus
  logic scsi_in_take;
  logic scsi_out_take;
  logic [`FIFO_CNT_W-1:0] offset_lim;
  assign in_mode = (st_r.state == ST_IN);
  assign out_mode = (st_r.state == ST_OUT);
  assign start_ok = xfer_start & dma_mode;
  assign f_flush = start_ok;
  // offset clamp keeps scsi intake within eight bytes of the fifo
  assign offset_lim = (sync_offset == 4'h0 || sync_offset > `OFFSET_MAX) ?
      `OFFSET_MAX : sync_offset;
  // ****************************************
  // fifo port steering
  // ****************************************
  // input transfer: scsi fills, hold register drains; output is the reverse
  assign scsi_in_take = in_mode & scsi_in_valid & ~f_full &
      (st_r.scsi_left != `XFER_CNT_ZERO) & (f_cnt < offset_lim);
  assign scsi_in_ready = in_mode & ~f_full &
      (st_r.scsi_left != `XFER_CNT_ZERO) & (f_cnt < offset_lim);
  assign load_hold = in_mode & ~f_empty & (~st_r.hold_valid | resp_fall);
  assign scsi_out_valid = out_mode & ~f_empty;
  assign scsi_out_take = scsi_out_valid & scsi_out_ready;
  assign scsi_out_data = f_rdata;
  // capture byte at response trailing edge in output transfers
  assign f_wr = scsi_in_take | (out_mode & resp_fall & ~f_full);
  assign f_wdata = in_mode ? scsi_in_data : st_r.din_s2;
  assign f_rd = load_hold | scsi_out_take;
  // ****************************************
  // next-state logic
  // ****************************************
  always_comb begin
    st_nxt = st_r;
    // data lines pass two flops before use
    st_nxt.din_s1 = dma_data_bus_in;
    st_nxt.din_s2 = st_r.din_s1;
    st_nxt.dpar_s1 = dma_data_parity_in;
    st_nxt.dpar_s2 = st_r.dpar_s1;
    st_nxt.done = 1'b0;
    unique case (st_r.state)
      ST_IDLE: begin
        st_nxt.req = 1'b0;
        st_nxt.hold_valid = 1'b0;
        if (start_ok && xfer_count != `XFER_CNT_ZERO) begin
          st_nxt.dma_left = xfer_count;
          st_nxt.scsi_left = xfer_count;
          st_nxt.perr = 1'b0;
          st_nxt.oerr = 1'b0;
          st_nxt.state = xfer_is_output ? ST_OUT : ST_IN;
        end
      end
      ST_IN: begin
        if (scsi_in_take) begin
          st_nxt.scsi_left = st_r.scsi_left - `XFER_CNT_ONE;
        end
        // trailing edge of response ends one byte
        if (resp_fall && st_r.hold_valid) begin
          st_nxt.dma_left = st_r.dma_left - `XFER_CNT_ONE;
          st_nxt.hold_valid = 1'b0;
        end
        // byte held until response falls, then next may follow
        if (load_hold) begin
          st_nxt.hold_data = f_rdata;
          st_nxt.hold_par = odd_par(f_rdata);
          st_nxt.hold_valid = 1'b1;
        end
        if (resp_fall && !st_r.hold_valid) begin
          st_nxt.oerr = 1'b1; // response with nothing offered
        end
        // level request while a byte is available for memory
        st_nxt.req = st_nxt.hold_valid;
        if (resp_fall && st_r.hold_valid && st_r.dma_left == `XFER_CNT_ONE) begin
          st_nxt.state = ST_IDLE;
          st_nxt.req = 1'b0;
          st_nxt.done = 1'b1;
        end
      end
      ST_OUT: begin
        if (resp_fall) begin
          if (f_full || st_r.dma_left == `XFER_CNT_ZERO) begin
            st_nxt.oerr = 1'b1; // byte offered with no request standing
          end else begin
            st_nxt.dma_left = st_r.dma_left - `XFER_CNT_ONE;
            if (st_r.dpar_s2 != odd_par(st_r.din_s2)) begin
              st_nxt.perr = 1'b1;
            end
          end
        end
        if (scsi_out_take) begin
          st_nxt.scsi_left = st_r.scsi_left - `XFER_CNT_ONE;
        end
        // request only while prefetch remains and a location is free;
        // full count uses the post-update fifo level to drop at once
        st_nxt.req = (st_nxt.dma_left != `XFER_CNT_ZERO) &&
            (f_cnt + {3'h0, f_wr} - {3'h0, f_rd} < `FIFO_DEPTH);
        if (scsi_out_take && st_r.scsi_left == `XFER_CNT_ONE) begin
          st_nxt.state = ST_IDLE;
          st_nxt.req = 1'b0;
          st_nxt.done = 1'b1;
        end
      end
      default: begin
        st_nxt.state = ST_IDLE;
        st_nxt.req = 1'b0;
      end
    endcase
    if (!dma_mode) begin
      st_nxt.state = ST_IDLE; // leaving dma mode aborts the transfer
      st_nxt.req = 1'b0;
    end
  end
  // ****************************************
  // register
  // ****************************************
  always_ff @(posedge clock or negedge rst_l_n) begin
    if (!rst_l_n) begin
      st_r <= '0;
      st_r.state <= ST_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end
  // ****************************************
  // outputs
  // ****************************************
  // direction alone picks drive; external logic owns it
  assign dma_data_oe_n = ~dir_s;
  assign dma_data_bus_out = st_r.hold_data;
  assign dma_data_parity_out = st_r.hold_par;
  assign buffer_transfer_request = st_r.req;
  assign xfer_done = st_r.done;
  assign busy = ~st_r.state[0];
  assign parity_error = st_r.perr;
  assign offset_error = st_r.oerr;
  // ****************************************
  // assertions
  // ****************************************
  // enable must be the pin seen through exactly two flops, once the chain is live
  a_oe_follows_dir: assert property (
    @(posedge clock) disable iff (!rst_l_n)
    $past(rst_l_n, 2) |-> (dma_data_oe_n == !$past(dma_bus_direction_in, 2)))
    else $error("oe does not follow direction");
  a_full_drops_req: assert property (
    @(posedge clock) disable iff (!rst_l_n)
    (out_mode && f_full) |-> !buffer_transfer_request)
    else $error("request with full fifo");
  a_out_req_count: assert property (
    @(posedge clock) disable iff (!rst_l_n)
    (out_mode && st_r.dma_left == `XFER_CNT_ZERO) |-> !buffer_transfer_request)
    else $error("request past count");
  a_in_req_data: assert property (
    @(posedge clock) disable iff (!rst_l_n)
    in_mode |-> (buffer_transfer_request == st_r.hold_valid))
    else $error("input request mismatch");
  a_hold_stable: assert property (
    @(posedge clock) disable iff (!rst_l_n)
    (in_mode && st_r.hold_valid && !resp_fall) |=> $stable(dma_data_bus_out))
    else $error("input byte changed early");
  a_capture_edge: assert property (
    @(posedge clock) disable iff (!rst_l_n)
    (out_mode && resp_fall && !f_full && st_r.dma_left != `XFER_CNT_ZERO)
    |=> (st_r.dma_left == $past(st_r.dma_left) - `XFER_CNT_ONE))
    else $error("output byte not counted");
  // an edge counts only when the pin fell three clocks back, so once per pulse
  a_single_pulse: assert property (
    @(posedge clock) disable iff (!rst_l_n)
    resp_fall |-> (!$past(buffer_transfer_response, 2) && $past(buffer_transfer_response, 3)))
    else $error("response edge not from one pin fall");
  a_fifo_bound: assert property (
    @(posedge clock) disable iff (!rst_l_n)
    f_cnt <= `FIFO_DEPTH) else $error("fifo over depth");
  a_count_stable: assert property (
    @(posedge clock) disable iff (!rst_l_n)
    (busy && !resp_fall && !scsi_in_take && !scsi_out_take && !start_ok)
    |=> $stable(st_r.dma_left)) else $error("counter moved without byte");
  c_in_done: cover property (@(posedge clock) disable iff (!rst_l_n)
    in_mode ##1 xfer_done);
  c_out_done: cover property (@(posedge clock) disable iff (!rst_l_n)
    out_mode ##1 xfer_done);
  c_out_full: cover property (@(posedge clock) disable iff (!rst_l_n)
    out_mode && f_full);
  // response pulses are several clocks apart, so the second edge sits in a window
  c_req_multi: cover property (@(posedge clock) disable iff (!rst_l_n)
    (buffer_transfer_request && resp_fall) ##1 buffer_transfer_request [*8]
    ##[1:40] (buffer_transfer_request && resp_fall));
endmodule : external_buffer_dma_port

/* File: bench/ext_buf_model.sv */
/*
 behavioural model of the external buffer control logic on the dma side.
 assumes the bench loads tx_q for output transfers and reads rx_q afterwards.
*/
`timescale 1ns/1ns
module ext_buf_model (
  input wire logic clock,
  input wire logic request,
  input dma_port_pkg::byte_t data_out,
  input wire logic parity_out,
  input wire logic go,
  input wire logic out_mode,
  input wire logic slow,
  output logic direction,
  output logic response,
  output dma_port_pkg::byte_t data_in,
  output logic parity_in
);
  import dma_port_pkg::*;
  byte_t tx_q[$]; // bytes still to offer in output transfers
  byte_t rx_q[$]; // bytes taken in input transfers
  int n_bad; // received bytes with wrong odd parity
  byte_t cur;
  // direction follows the transfer kind; high only for input transfers
  assign direction = go & ~out_mode;
  // ****************************************
  // one response pulse per byte while request stands
  // ****************************************
  initial begin
    response = 1'b0;
    data_in = 8'h5A;
    parity_in = 1'b1;
    n_bad = 0;
    forever begin
      @(posedge clock);
      // several bytes may go under one request level
      if (go && request && (!out_mode || tx_q.size() > 0)) begin
        if (out_mode) begin
          cur = tx_q.pop_front();
          data_in <= cur;
          parity_in <= ~^cur;
        end
        repeat (3) @(posedge clock);
        response <= 1'b1;
        repeat (slow ? 7 : 3) @(posedge clock);
        if (!out_mode) begin
          rx_q.push_back(data_out);
          if (parity_out !== ~^data_out) n_bad++;
        end
        response <= 1'b0;
        repeat (4) @(posedge clock);
        // hold time over: show the inverse so a late sample is caught
        data_in <= ~data_in;
        parity_in <= ~parity_in;
        repeat (2) @(posedge clock);
      end
    end
  end
endmodule : ext_buf_model

/* File: bench/tb_top.sv */
/*
 self-checking bench for the external buffer dma port.
 assumes the design files and ext_buf_model are compiled first.
*/
`timescale 1ns/1ns
module tb_top;
  import dma_port_pkg::*;
  logic clock, rst_n, dma_mode, xfer_start, xfer_is_output, go, out_mode, slow;
  logic scsi_in_valid, scsi_out_ready, d_par, m_par, par, oe_n, dir, resp, req;
  logic in_ready, out_valid, off_err, done, busy, par_err;
  xfer_cnt_t xfer_count;
  fifo_cnt_t sync_off; // scsi intake limit handed to the design
  byte_t scsi_in_data, scsi_out_data, d_out, m_out, bus;
  int miscompares, num_checks;
  // wire level: device drives only while its enable is low
  assign bus = oe_n ? m_out : d_out;
  assign par = oe_n ? m_par : d_par;
  external_buffer_dma_port external_buffer_dma_port_i (.clock(clock), .rst_n(rst_n),
    .dma_mode(dma_mode), .xfer_start(xfer_start), .xfer_is_output(xfer_is_output),
    .xfer_count(xfer_count), .dma_bus_direction_in(dir), .buffer_transfer_response(resp),
    .dma_data_bus_in(bus), .dma_data_parity_in(par), .dma_data_bus_out(d_out),
    .dma_data_parity_out(d_par), .dma_data_oe_n(oe_n), .buffer_transfer_request(req),
    .scsi_in_valid(scsi_in_valid), .scsi_in_data(scsi_in_data), .scsi_in_ready(in_ready),
    .scsi_out_valid(out_valid), .scsi_out_data(scsi_out_data),
    .scsi_out_ready(scsi_out_ready), .sync_offset(sync_off), .offset_error(off_err),
    .xfer_done(done), .busy(busy), .parity_error(par_err));
  ext_buf_model ext_buf_model_i (.clock(clock), .request(req), .data_out(bus),
    .parity_out(par), .go(go), .out_mode(out_mode), .slow(slow), .direction(dir),
    .response(resp), .data_in(m_out), .parity_in(m_par));
  // ****************************************
  // reporting and compare helpers
  // ****************************************
  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : close_out
  task automatic check_bit(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: bit %b, wanted %b", $time, got, exp);
    end
  endtask : check_bit
  task automatic check_byte(input byte_t got, input byte_t exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: byte %h, wanted %h", $time, got, exp);
    end
  endtask : check_byte
  // a bounded wait that ran out ends the run
  task automatic timed_out;
    miscompares++;
    $display("unexpected at %0t: wait ran out", $time);
    close_out();
  endtask : timed_out
  task automatic wait_done;
    int i;
    for (i = 0; i < 3000 && done !== 1'b1; i++) @(negedge clock);
    if (i == 3000) timed_out();
  endtask : wait_done
  task automatic start_xfer(input logic is_out, input xfer_cnt_t cnt);
    @(negedge clock);
    xfer_start = 1'b1;
    xfer_is_output = is_out;
    xfer_count = cnt;
    @(negedge clock);
    xfer_start = 1'b0;
  endtask : start_xfer
  // scsi side stream: a byte goes on the edge after ready is seen
  task automatic push_bytes(input int n, input byte_t base);
    int k;
    for (int i = 0; i < n; i++) begin
      scsi_in_valid = 1'b1;
      scsi_in_data = base + byte_t'(i);
      #1;
      for (k = 0; k < 3000 && in_ready !== 1'b1; k++) @(negedge clock) #1;
      if (k == 3000) timed_out();
      @(negedge clock);
    end
    scsi_in_valid = 1'b0;
  endtask : push_bytes
  // ****************************************
  // scenarios
  // ****************************************
  task automatic sc_refused;
    dma_mode = 1'b0;
    start_xfer(1'b0, 24'h000004);
    check_bit(busy, 1'b0);
    dma_mode = 1'b1;
    start_xfer(1'b0, 24'h000000);
    check_bit(busy, 1'b0);
    check_bit(req, 1'b0);
    check_bit(oe_n, 1'b1);
    // leaving dma mode mid-transfer drops back to idle
    start_xfer(1'b0, 24'h000004);
    push_bytes(1, 8'h11);
    repeat (4) @(negedge clock);
    check_bit(req, 1'b1);
    dma_mode = 1'b0;
    repeat (2) @(negedge clock);
    check_bit(busy, 1'b0);
    check_bit(req, 1'b0);
    dma_mode = 1'b1;
  endtask : sc_refused
  task automatic sc_input;
    int lows;
    int n;
    lows = 0;
    out_mode = 1'b0;
    slow = 1'b1;
    start_xfer(1'b0, 24'h00000A);
    fork
      push_bytes(10, 8'h30);
      begin
        repeat (40) @(negedge clock);
        check_bit(req, 1'b1);
        check_bit(oe_n, 1'b1);
        go = 1'b1;
        repeat (8) @(negedge clock);
        check_bit(oe_n, 1'b0);
        for (n = 0; n < 2000 && ext_buf_model_i.rx_q.size() < 6; n++) begin
          @(negedge clock);
          if (req !== 1'b1) lows++;
        end
        if (n == 2000) timed_out();
      end
    join
    check_bit(lows == 0, 1'b1);
    wait_done();
    repeat (8) @(negedge clock);
    check_bit(req, 1'b0);
    check_byte(byte_t'(ext_buf_model_i.rx_q.size()), 8'h0A);
    for (int i = 0; i < 10; i++) check_byte(ext_buf_model_i.rx_q[i], 8'h30 + byte_t'(i));
    check_bit(ext_buf_model_i.n_bad == 0, 1'b1);
    go = 1'b0;
  endtask : sc_input
  // a small offset holds scsi intake to that many fifo bytes
  task automatic sc_offset;
    sync_off = 4'h2;
    out_mode = 1'b0;
    start_xfer(1'b0, 24'h000004);
    push_bytes(3, 8'h50);
    repeat (2) @(negedge clock);
    check_bit(in_ready, 1'b0);
    go = 1'b1;
    push_bytes(1, 8'h53);
    wait_done();
    check_byte(byte_t'(ext_buf_model_i.rx_q.size()), 8'h0E);
    check_byte(ext_buf_model_i.rx_q[13], 8'h53);
    go = 1'b0;
    sync_off = 4'h8;
  endtask : sc_offset
  task automatic sc_output;
    int k;
    int j;
    for (int i = 0; i < 10; i++) ext_buf_model_i.tx_q.push_back(8'hC0 + byte_t'(i));
    out_mode = 1'b1;
    slow = 1'b0;
    go = 1'b1;
    start_xfer(1'b1, 24'h00000A);
    for (k = 0; k < 2000 && ext_buf_model_i.tx_q.size() > 2; k++) @(negedge clock);
    if (k == 2000) timed_out();
    repeat (14) @(negedge clock);
    check_bit(req, 1'b0);
    check_bit(oe_n, 1'b1);
    check_byte(byte_t'(ext_buf_model_i.tx_q.size()), 8'h02);
    scsi_out_ready = 1'b1;
    k = 0;
    // look before the edge that takes the byte, else the first one is missed
    for (j = 0; j < 3000 && k < 10; j++) begin
      if (out_valid === 1'b1) begin
        check_byte(scsi_out_data, 8'hC0 + byte_t'(k));
        k++;
      end
      @(negedge clock);
    end
    if (j == 3000) timed_out();
    wait_done();
    repeat (8) @(negedge clock);
    check_bit(req, 1'b0);
    check_bit(par_err, 1'b0);
    check_bit(off_err, 1'b0);
    scsi_out_ready = 1'b0;
    go = 1'b0;
  endtask : sc_output
  // ****************************************
  // clock, reset and main sequence
  // ****************************************
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  initial begin
    miscompares = 0;
    num_checks = 0;
    rst_n = 1'b0;
    {dma_mode, xfer_start, xfer_is_output, go, out_mode, slow} = 6'h00;
    {scsi_in_valid, scsi_out_ready} = 2'h0;
    xfer_count = 24'h000000;
    scsi_in_data = 8'h00;
    sync_off = 4'h8;
    repeat (6) @(negedge clock);
    rst_n = 1'b1;
    repeat (5) @(negedge clock);
    check_bit(oe_n, 1'b1);
    check_bit(req, 1'b0);
    check_bit(busy, 1'b0);
    sc_refused();
    sc_input();
    sc_offset();
    sc_output();
    close_out();
  end
endmodule : tb_top
